/* File: pkg/cabx_cfg.svh */
`ifndef CABX_CFG_SVH
`define CABX_CFG_SVH
// Notes on behaviour
// [RULE1] Add two registers, optionally plus carry, one cycle; Z C N V H updated.
// [RULE2] Subtract register or constant, optionally minus carry, one cycle; Z C N V H updated.
// [RULE3] Word add or subtract immediate, two cycles; Z C N V S updated, H kept.
// [RULE4] AND, OR, XOR with register or constant, one cycle; only Z N V updated.
// [RULE5] Set mask ORs constant; clear mask ANDs with 0xFF minus mask; one cycle.
// [RULE6] Zero-sign test ANDs register with itself, value kept, Z N V updated.
// [RULE7] Jump via pointer loads PC from Z, two cycles, no flags.
// [RULE8] Call via pointer pushes return address, PC from Z, three cycles.
// [RULE9] Compare-skip-equal skips next instruction when equal; PC plus 2 or 3.
// [RULE10] Compares form difference without storing it, update Z N V C H.
// [RULE11] Register bit skips skip next when bit clear, or set; 1/2/3 cycles.
// [RULE12] I/O bit skips skip next when I/O bit clear, or set; 1/2/3 cycles.
// [RULE13] Flag branches add offset plus one when flag set, or clear; 1 or 2 cycles.
// [RULE14] Carry branches taken when carry clear, or set; 1 untaken, 2 taken.
// [RULE15] Relative jump 2, relative call 3, exits 4 cycles; interrupt exit sets I.
// [RULE16] Bitwise invert gives 0xFF minus value, twos invert zero minus value.
// [RULE17] Not-equal branch when Z clear, equal branch when Z set.
`define CABX_FLAG_C 0
`define CABX_FLAG_Z 1
`define CABX_FLAG_N 2
`define CABX_FLAG_V 3
`define CABX_FLAG_S 4
`define CABX_FLAG_H 5
`define CABX_FLAG_T 6
`define CABX_FLAG_I 7
`define CABX_PC_RESET 16'h0000
`define CABX_STATUS_RESET 8'h00
`define CABX_BYTE_ONES 8'hFF
`define CABX_BYTE_ZERO 8'h00
`define CABX_WORD_ZERO 16'h0000
`define CABX_PC_STEP 16'h0001
`define CABX_SKIP_ONE 16'h0002
`define CABX_SKIP_TWO 16'h0003
`define CABX_EXTRA_NONE 2'h0
`define CABX_EXTRA_ONE 2'h1
`define CABX_EXTRA_TWO 2'h2
`define CABX_EXTRA_THREE 2'h3
`endif

/* File: pkg/cabx_pkg.sv */
package cabx_pkg;
  typedef enum logic [5:0] {
    OP_ADD = 6'h00, OP_ADD_CARRY = 6'h01, OP_MINUS = 6'h02, OP_MINUS_CONSTANT = 6'h03,
    OP_MINUS_WITH_BORROW = 6'h04, OP_MINUS_CONSTANT_WITH_BORROW = 6'h05,
    OP_WORD_ADD_IMMEDIATE = 6'h06, OP_WORD_MINUS_IMMEDIATE = 6'h07,
    OP_AND = 6'h08, OP_AND_WITH_CONSTANT = 6'h09, OP_OR = 6'h0A, OP_OR_WITH_CONSTANT = 6'h0B,
    OP_EXCLUSIVE_OR_REGISTERS = 6'h0C, OP_SET_MASK_BITS = 6'h0D, OP_CLEAR_MASK_BITS = 6'h0E,
    OP_ZERO_SIGN_TEST = 6'h0F, OP_BITWISE_INVERT = 6'h10, OP_TWOS_INVERT = 6'h11,
    OP_COMPARE_REGISTERS = 6'h12, OP_COMPARE_WITH_BORROW = 6'h13, OP_COMPARE_WITH_CONSTANT = 6'h14,
    OP_JUMP_VIA_POINTER = 6'h15, OP_CALL_VIA_POINTER = 6'h16, OP_RELATIVE_JUMP = 6'h17,
    OP_RELATIVE_CALL = 6'h18, OP_ROUTINE_EXIT = 6'h19, OP_INTERRUPT_EXIT = 6'h1A,
    OP_COMPARE_SKIP_EQUAL = 6'h1B, OP_SKIP_REG_BIT_CLEAR = 6'h1C, OP_SKIP_REG_BIT_SET = 6'h1D,
    OP_SKIP_IO_BIT_CLEAR = 6'h1E, OP_SKIP_IO_BIT_SET = 6'h1F,
    OP_BRANCH_FLAG_SET = 6'h20, OP_BRANCH_FLAG_CLEAR = 6'h21, OP_BRANCH_CARRY_SET = 6'h22,
    OP_BRANCH_CARRY_CLEAR = 6'h23, OP_BRANCH_SAME_OR_HIGHER = 6'h24, OP_BRANCH_EQUAL = 6'h25,
    OP_BRANCH_NOT_EQUAL = 6'h26, OP_NONE = 6'h3F
  } cabx_op_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } cabx_state_e;
endpackage

/* File: pkg/cabx_alu_if.sv */
`timescale 1ns/1ps
interface cabx_alu_if;
  import cabx_pkg::*;
  cabx_op_e op;
  logic [7:0] a;
  logic [7:0] b;
  logic [15:0] word;
  logic [7:0] flagsIn;
  logic [7:0] res;
  logic [15:0] wordRes;
  logic [7:0] flagsOut;
  logic resWrite;
  logic wordWrite;
  modport alu (input op, a, b, word, flagsIn, output res, wordRes, flagsOut, resWrite, wordWrite);
  modport core (output op, a, b, word, flagsIn, input res, wordRes, flagsOut, resWrite, wordWrite);
endinterface

/* File: verilog/cabx_alu.sv */
`timescale 1ns/1ps
`include "cabx_cfg.svh"
module cabx_alu import cabx_pkg::*; (
  // Operands and results
  cabx_alu_if.alu ab
);
  // Returns {half, overflow, carry} of a plus b giving r
  function automatic logic [2:0] addHvc(input logic [7:0] a, input logic [7:0] b, input logic [7:0] r);
    addHvc = {(a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]),
              (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]),
              (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7])};
  endfunction

  // Returns {half, overflow, borrow} of a minus b giving r
  function automatic logic [2:0] subHvc(input logic [7:0] a, input logic [7:0] b, input logic [7:0] r);
    subHvc = {(~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]),
              (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]),
              (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7])};
  endfunction

  // Z N V C H update; borrow forms keep Z only while the result stays zero
  function automatic logic [7:0] arithFlags(input logic [7:0] f, input logic [7:0] r, input logic [2:0] hvc,
                                            input logic keepZ);
    logic [7:0] o;
    o = f;
    o[`CABX_FLAG_Z] = (r == `CABX_BYTE_ZERO) & (~keepZ | f[`CABX_FLAG_Z]);
    o[`CABX_FLAG_N] = r[7];
    o[`CABX_FLAG_H] = hvc[2];
    o[`CABX_FLAG_V] = hvc[1];
    o[`CABX_FLAG_C] = hvc[0];
    arithFlags = o;
  endfunction

  function automatic logic [7:0] logicFlags(input logic [7:0] f, input logic [7:0] r);
    logic [7:0] o;
    o = f;
    o[`CABX_FLAG_Z] = (r == `CABX_BYTE_ZERO);
    o[`CABX_FLAG_N] = r[7];
    o[`CABX_FLAG_V] = 1'b0;
    logicFlags = o;
  endfunction

  always_comb begin
    logic [7:0] r;
    logic [15:0] w;
    logic borrow;
    r = `CABX_BYTE_ZERO;
    w = `CABX_WORD_ZERO;
    borrow = 1'b0;
    ab.res = `CABX_BYTE_ZERO;
    ab.wordRes = `CABX_WORD_ZERO;
    ab.flagsOut = ab.flagsIn;
    ab.resWrite = 1'b0;
    ab.wordWrite = 1'b0;
    case (ab.op)
      OP_ADD, OP_ADD_CARRY: begin
        r = ab.a + ab.b + {7'h00, (ab.op == OP_ADD_CARRY) & ab.flagsIn[`CABX_FLAG_C]}; // RULE1
        ab.flagsOut = arithFlags(ab.flagsIn, r, addHvc(ab.a, ab.b, r), 1'b0); // RULE1
        ab.resWrite = 1'b1;
      end
      OP_MINUS, OP_MINUS_CONSTANT, OP_MINUS_WITH_BORROW, OP_MINUS_CONSTANT_WITH_BORROW,
      OP_COMPARE_REGISTERS, OP_COMPARE_WITH_BORROW, OP_COMPARE_WITH_CONSTANT: begin
        borrow = (ab.op == OP_MINUS_WITH_BORROW) || (ab.op == OP_MINUS_CONSTANT_WITH_BORROW) ||
                 (ab.op == OP_COMPARE_WITH_BORROW);
        r = ab.a - ab.b - {7'h00, borrow & ab.flagsIn[`CABX_FLAG_C]}; // RULE2
        ab.flagsOut = arithFlags(ab.flagsIn, r, subHvc(ab.a, ab.b, r), borrow); // RULE10
        ab.resWrite = (ab.op != OP_COMPARE_REGISTERS) && (ab.op != OP_COMPARE_WITH_BORROW) &&
                      (ab.op != OP_COMPARE_WITH_CONSTANT); // RULE10
      end
      OP_TWOS_INVERT: begin
        r = `CABX_BYTE_ZERO - ab.a; // RULE16
        ab.flagsOut = arithFlags(ab.flagsIn, r, subHvc(`CABX_BYTE_ZERO, ab.a, r), 1'b0);
        ab.resWrite = 1'b1;
      end
      OP_BITWISE_INVERT: begin
        r = `CABX_BYTE_ONES - ab.a; // RULE16
        ab.flagsOut = logicFlags(ab.flagsIn, r);
        ab.flagsOut[`CABX_FLAG_C] = 1'b1;
        ab.resWrite = 1'b1;
      end
      OP_AND, OP_AND_WITH_CONSTANT, OP_ZERO_SIGN_TEST: begin
        r = ab.a & ((ab.op == OP_ZERO_SIGN_TEST) ? ab.a : ab.b); // RULE6
        ab.flagsOut = logicFlags(ab.flagsIn, r); // RULE4
        ab.resWrite = (ab.op != OP_ZERO_SIGN_TEST); // RULE6
      end
      OP_OR, OP_OR_WITH_CONSTANT, OP_SET_MASK_BITS: begin
        r = ab.a | ab.b; // RULE5
        ab.flagsOut = logicFlags(ab.flagsIn, r); // RULE4
        ab.resWrite = 1'b1;
      end
      OP_EXCLUSIVE_OR_REGISTERS, OP_CLEAR_MASK_BITS: begin
        r = (ab.op == OP_CLEAR_MASK_BITS) ? (ab.a & (`CABX_BYTE_ONES - ab.b)) : (ab.a ^ ab.b); // RULE5
        ab.flagsOut = logicFlags(ab.flagsIn, r); // RULE4
        ab.resWrite = 1'b1;
      end
      OP_WORD_ADD_IMMEDIATE, OP_WORD_MINUS_IMMEDIATE: begin
        if (ab.op == OP_WORD_ADD_IMMEDIATE) begin
          w = ab.word + {8'h00, ab.b}; // RULE3
          ab.flagsOut[`CABX_FLAG_V] = ~ab.word[15] & w[15];
          ab.flagsOut[`CABX_FLAG_C] = ~w[15] & ab.word[15];
        end else begin
          w = ab.word - {8'h00, ab.b}; // RULE3
          ab.flagsOut[`CABX_FLAG_V] = ab.word[15] & ~w[15];
          ab.flagsOut[`CABX_FLAG_C] = w[15] & ~ab.word[15];
        end
        ab.flagsOut[`CABX_FLAG_Z] = (w == `CABX_WORD_ZERO);
        ab.flagsOut[`CABX_FLAG_N] = w[15];
        ab.flagsOut[`CABX_FLAG_S] = w[15] ^ ab.flagsOut[`CABX_FLAG_V]; // RULE3
        ab.wordWrite = 1'b1;
      end
      default: begin
        r = `CABX_BYTE_ZERO;
      end
    endcase
    ab.res = r;
    ab.wordRes = w;
  end
endmodule

/* File: verilog/cabx_exec.sv */
`timescale 1ns/1ps
`include "cabx_cfg.svh"
module cabx_exec import cabx_pkg::*; #(
  parameter int OffsetBits = 12
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Instruction request
  input wire logic opValid,
  output logic opReady,
  input wire cabx_op_e opCode,
  input wire logic [7:0] opA,
  input wire logic [7:0] opB,
  input wire logic [15:0] wordIn,
  input wire logic [15:0] zPtr,
  input wire logic [2:0] bitSel,
  input wire logic [2:0] flagSel,
  input wire logic signed [OffsetBits-1:0] brOffset,
  input wire logic nextTwoWord,
  input wire logic [7:0] ioData,
  input wire logic [15:0] stackData,
  // Results
  output logic resValid,
  output logic [7:0] resData,
  output logic wordValid,
  output logic [15:0] wordData,
  output logic pushValid,
  output logic [15:0] pushAddr,
  output logic [15:0] pcOut,
  output logic [7:0] statusFlags
);
  if (OffsetBits < 7 || OffsetBits > 16) begin
    $error("cabx_exec: OffsetBits must lie in 7..16");
  end

  cabx_alu_if aluBus();
  cabx_alu uAlu (.ab(aluBus.alu));

  cabx_state_e state_q, state_d;
  logic [1:0] cnt_q, cnt_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0] status_q, status_d;
  logic [7:0] resData_q, resData_d;
  logic [15:0] wordData_q, wordData_d;
  logic [15:0] pushAddr_q, pushAddr_d;
  logic resValid_q, resValid_d;
  logic wordValid_q, wordValid_d;
  logic pushValid_q, pushValid_d;
  logic take;
  logic [15:0] offExt;
  logic [15:0] relTarget;
  logic [15:0] skipTarget;

  assign aluBus.op = opCode;
  assign aluBus.a = opA;
  assign aluBus.b = opB;
  assign aluBus.word = wordIn;
  assign aluBus.flagsIn = status_q;

  assign opReady = (state_q == ST_IDLE);
  assign take = opValid && opReady;
  assign offExt = {{(16 - OffsetBits){brOffset[OffsetBits-1]}}, brOffset};
  assign relTarget = pc_q + offExt + `CABX_PC_STEP;
  assign skipTarget = pc_q + (nextTwoWord ? `CABX_SKIP_TWO : `CABX_SKIP_ONE);

  always_comb begin
    logic [1:0] extra;
    logic skip;
    logic branch;
    extra = `CABX_EXTRA_NONE;
    skip = 1'b0;
    branch = 1'b0;
    state_d = state_q;
    cnt_d = cnt_q;
    pc_d = pc_q;
    status_d = status_q;
    resData_d = resData_q;
    wordData_d = wordData_q;
    pushAddr_d = pushAddr_q;
    resValid_d = 1'b0;
    wordValid_d = 1'b0;
    pushValid_d = 1'b0;
    if (state_q == ST_BUSY) begin
      cnt_d = cnt_q - `CABX_EXTRA_ONE;
      if (cnt_q == `CABX_EXTRA_ONE) begin
        state_d = ST_IDLE;
      end
    end
    if (take) begin
      pc_d = pc_q + `CABX_PC_STEP;
      status_d = aluBus.flagsOut;
      resValid_d = aluBus.resWrite;
      wordValid_d = aluBus.wordWrite;
      if (aluBus.resWrite) begin
        resData_d = aluBus.res;
      end
      if (aluBus.wordWrite) begin
        wordData_d = aluBus.wordRes;
      end
      case (opCode)
        OP_WORD_ADD_IMMEDIATE, OP_WORD_MINUS_IMMEDIATE: begin
          extra = `CABX_EXTRA_ONE; // RULE3
        end
        OP_JUMP_VIA_POINTER: begin
          pc_d = zPtr; // RULE7
          extra = `CABX_EXTRA_ONE;
        end
        OP_CALL_VIA_POINTER, OP_RELATIVE_CALL: begin
          pc_d = (opCode == OP_CALL_VIA_POINTER) ? zPtr : relTarget; // RULE8
          pushValid_d = 1'b1;
          pushAddr_d = pc_q + `CABX_PC_STEP;
          extra = `CABX_EXTRA_TWO; // RULE15
        end
        OP_RELATIVE_JUMP: begin
          pc_d = relTarget; // RULE15
          extra = `CABX_EXTRA_ONE;
        end
        OP_ROUTINE_EXIT, OP_INTERRUPT_EXIT: begin
          pc_d = stackData; // RULE15
          if (opCode == OP_INTERRUPT_EXIT) begin
            status_d[`CABX_FLAG_I] = 1'b1;
          end
          extra = `CABX_EXTRA_THREE;
        end
        OP_COMPARE_SKIP_EQUAL: skip = (opA == opB); // RULE9
        OP_SKIP_REG_BIT_CLEAR: skip = ~opA[bitSel]; // RULE11
        OP_SKIP_REG_BIT_SET: skip = opA[bitSel]; // RULE11
        OP_SKIP_IO_BIT_CLEAR: skip = ~ioData[bitSel]; // RULE12
        OP_SKIP_IO_BIT_SET: skip = ioData[bitSel]; // RULE12
        OP_BRANCH_FLAG_SET: branch = status_q[flagSel]; // RULE13
        OP_BRANCH_FLAG_CLEAR: branch = ~status_q[flagSel]; // RULE13
        OP_BRANCH_CARRY_SET: branch = status_q[`CABX_FLAG_C]; // RULE14
        OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER: branch = ~status_q[`CABX_FLAG_C]; // RULE14
        OP_BRANCH_EQUAL: branch = status_q[`CABX_FLAG_Z]; // RULE17
        OP_BRANCH_NOT_EQUAL: branch = ~status_q[`CABX_FLAG_Z]; // RULE17
        default: extra = `CABX_EXTRA_NONE;
      endcase
      if (skip) begin
        pc_d = skipTarget; // RULE9
        extra = nextTwoWord ? `CABX_EXTRA_TWO : `CABX_EXTRA_ONE;
      end
      if (branch) begin
        pc_d = relTarget; // RULE13
        extra = `CABX_EXTRA_ONE;
      end
      if (extra != `CABX_EXTRA_NONE) begin
        state_d = ST_BUSY;
        cnt_d = extra;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= `CABX_EXTRA_NONE;
      pc_q <= `CABX_PC_RESET;
      status_q <= `CABX_STATUS_RESET;
      resData_q <= `CABX_BYTE_ZERO;
      wordData_q <= `CABX_WORD_ZERO;
      pushAddr_q <= `CABX_WORD_ZERO;
      resValid_q <= 1'b0;
      wordValid_q <= 1'b0;
      pushValid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pc_q <= pc_d;
      status_q <= status_d;
      resData_q <= resData_d;
      wordData_q <= wordData_d;
      pushAddr_q <= pushAddr_d;
      resValid_q <= resValid_d;
      wordValid_q <= wordValid_d;
      pushValid_q <= pushValid_d;
    end
  end

  assign pcOut = pc_q;
  assign statusFlags = status_q;
  assign resData = resData_q;
  assign wordData = wordData_q;
  assign pushAddr = pushAddr_q;
  assign resValid = resValid_q;
  assign wordValid = wordValid_q;
  assign pushValid = pushValid_q;

  // Checks
  logic carryNow;
  logic zeroNow;
  logic halfNow;
  assign carryNow = status_q[`CABX_FLAG_C];
  assign zeroNow = status_q[`CABX_FLAG_Z];
  assign halfNow = status_q[`CABX_FLAG_H];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence sBusyOne;
    !opReady ##1 opReady;
  endsequence
  sequence sBusyTwo;
    !opReady [*2] ##1 opReady;
  endsequence
  sequence sBusyThree;
    !opReady [*3] ##1 opReady;
  endsequence

  a_add_carry_sum: assert property (take && opCode == OP_ADD_CARRY |=> resValid && opReady && // RULE1
    resData == 8'($past(opA) + $past(opB) + {7'h00, $past(carryNow)})) else $error("add with carry wrong");
  a_minus_borrow: assert property (take && opCode == OP_MINUS |=> resValid && // RULE2
    carryNow == ($past(opA) < $past(opB))) else $error("subtract borrow flag wrong");
  a_word_timing: assert property (take && opCode inside {OP_WORD_ADD_IMMEDIATE, OP_WORD_MINUS_IMMEDIATE} |=> // RULE3
    (wordValid && halfNow == $past(halfNow)) ##0 sBusyOne) else $error("word op timing or half flag wrong");
  a_logic_flags: assert property (take && opCode inside {OP_AND, OP_OR, OP_EXCLUSIVE_OR_REGISTERS} |=> // RULE4
    !status_q[`CABX_FLAG_V] && carryNow == $past(carryNow) && opReady) else $error("logic op flags wrong");
  a_clear_mask: assert property (take && opCode == OP_CLEAR_MASK_BITS |=> // RULE5
    resData == ($past(opA) & ~$past(opB))) else $error("clear mask result wrong");
  a_test_nowrite: assert property (take && opCode == OP_ZERO_SIGN_TEST |=> // RULE6
    !resValid && zeroNow == ($past(opA) == `CABX_BYTE_ZERO)) else $error("zero sign test wrong");
  a_pointer_jump: assert property (take && opCode == OP_JUMP_VIA_POINTER |=> // RULE7
    (pcOut == $past(zPtr) && !pushValid) ##0 sBusyOne) else $error("pointer jump wrong");
  a_pointer_call: assert property (take && opCode == OP_CALL_VIA_POINTER |=> // RULE8
    (pushValid && pushAddr == 16'($past(pcOut) + `CABX_PC_STEP) && pcOut == $past(zPtr)) ##0 sBusyTwo)
    else $error("pointer call wrong");
  a_skip_equal: assert property (take && opCode == OP_COMPARE_SKIP_EQUAL && opA == opB && nextTwoWord |=> // RULE9
    pcOut == 16'($past(pcOut) + `CABX_SKIP_TWO) ##0 sBusyTwo) else $error("equal skip wrong");
  a_compare_nostore: assert property (take && opCode == OP_COMPARE_REGISTERS |=> // RULE10
    !resValid && opReady && zeroNow == ($past(opA) == $past(opB))) else $error("compare wrong");
  a_reg_bit_fall: assert property (take && opCode == OP_SKIP_REG_BIT_SET && !opA[bitSel] |=> // RULE11
    pcOut == 16'($past(pcOut) + `CABX_PC_STEP) && opReady) else $error("register bit skip wrong");
  a_io_bit_skip: assert property (take && opCode == OP_SKIP_IO_BIT_CLEAR && !ioData[bitSel] && !nextTwoWord |=> // RULE12
    pcOut == 16'($past(pcOut) + `CABX_SKIP_ONE) ##0 sBusyOne) else $error("io bit skip wrong");
  a_flag_branch: assert property (take && opCode == OP_BRANCH_FLAG_SET && status_q[flagSel] |=> // RULE13
    pcOut == 16'($past(pcOut) + $past(offExt) + `CABX_PC_STEP) ##0 sBusyOne) else $error("flag branch wrong");
  a_carry_branch: assert property (take && opCode == OP_BRANCH_SAME_OR_HIGHER && carryNow |=> // RULE14
    pcOut == 16'($past(pcOut) + `CABX_PC_STEP) && opReady) else $error("carry branch wrong");
  a_exit_timing: assert property (take && opCode == OP_INTERRUPT_EXIT |=> // RULE15
    (pcOut == $past(stackData) && status_q[`CABX_FLAG_I]) ##0 sBusyThree) else $error("interrupt exit wrong");
  a_twos_invert: assert property (take && opCode == OP_TWOS_INVERT |=> // RULE16
    resValid && resData == 8'(`CABX_BYTE_ZERO - $past(opA))) else $error("twos invert wrong");
  a_not_equal: assert property (take && opCode == OP_BRANCH_NOT_EQUAL && zeroNow |=> // RULE17
    pcOut == 16'($past(pcOut) + `CABX_PC_STEP) && opReady) else $error("not-equal branch wrong");
endmodule

/* File: test/cabx_exec_tb.sv */
`timescale 1ns/1ps
module cabx_exec_tb import cabx_pkg::*; ;
  logic core_clk = 1'b0;
  logic arst_n, opValid, opReady, nextTwoWord;
  cabx_op_e opCode;
  logic [7:0] opA, opB, ioData, resData, statusFlags;
  logic [15:0] wordIn, zPtr, stackData, wordData, pushAddr, pcOut;
  logic [2:0] bitSel, flagSel;
  logic signed [11:0] brOffset;
  logic resValid, wordValid, pushValid, sawRes, sawWord, sawPush;
  int num_errors = 0;
  int cmp_count = 0;

  always #20 core_clk = ~core_clk;

  cabx_exec #(.OffsetBits(12)) i_cabx_exec (
    .core_clk(core_clk), .arst_n(arst_n), .opValid(opValid), .opReady(opReady),
    .opCode(opCode), .opA(opA), .opB(opB), .wordIn(wordIn), .zPtr(zPtr), .bitSel(bitSel),
    .flagSel(flagSel), .brOffset(brOffset), .nextTwoWord(nextTwoWord), .ioData(ioData),
    .stackData(stackData), .resValid(resValid), .resData(resData), .wordValid(wordValid),
    .wordData(wordData), .pushValid(pushValid), .pushAddr(pushAddr), .pcOut(pcOut),
    .statusFlags(statusFlags)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Compares %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Issue one instruction, then count cycles until ready again
  task automatic run(input cabx_op_e op, input logic [7:0] a, input logic [7:0] b, input int cyc);
    int n;
    @(posedge core_clk);
    opValid <= 1'b1;
    opCode <= op;
    opA <= a;
    opB <= b;
    @(posedge core_clk);
    opValid <= 1'b0;
    #1;
    sawRes = resValid;
    sawWord = wordValid;
    sawPush = pushValid;
    n = 1;
    while (opReady !== 1'b1 && n < 8) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (opReady !== 1'b1) begin
      num_errors++;
      tally_and_finish();
    end else begin
      chk(16'(n), 16'(cyc));
    end
  endtask

  task automatic test_add();
    run(OP_ADD, 8'h7F, 8'h01, 1);
    chk(resData, 8'h80);
    chk(sawRes, 1'b1);
    chk(statusFlags, 8'h2C);
    run(OP_ADD, 8'hFF, 8'h01, 1);
    chk(statusFlags, 8'h23);
    run(OP_ADD_CARRY, 8'h10, 8'h20, 1);
    chk(resData, 8'h31);
    chk(statusFlags, 8'h00);
    $display("test_add done");
  endtask

  task automatic test_sub();
    run(OP_MINUS, 8'h00, 8'h01, 1);
    chk(resData, 8'hFF);
    chk(statusFlags, 8'h25);
    run(OP_MINUS_CONSTANT_WITH_BORROW, 8'h05, 8'h04, 1);
    chk(resData, 8'h00);
    chk(statusFlags, 8'h00);
    run(OP_MINUS_CONSTANT, 8'h33, 8'h33, 1);
    chk(statusFlags, 8'h02);
    run(OP_MINUS_WITH_BORROW, 8'h20, 8'h20, 1);
    chk(statusFlags, 8'h02);
    run(OP_MINUS, 8'h80, 8'h01, 1);
    chk(resData, 8'h7F);
    chk(statusFlags, 8'h28);
    $display("test_sub done");
  endtask

  task automatic test_logic();
    cabx_op_e ops[7] = '{OP_AND, OP_AND_WITH_CONSTANT, OP_OR, OP_OR_WITH_CONSTANT,
      OP_EXCLUSIVE_OR_REGISTERS, OP_SET_MASK_BITS, OP_CLEAR_MASK_BITS};
    logic [7:0] va[7] = '{8'hF0, 8'hF3, 8'h80, 8'h00, 8'hFF, 8'h10, 8'hFF};
    logic [7:0] vb[7] = '{8'h0F, 8'h3C, 8'h01, 8'h00, 8'h0F, 8'h82, 8'h0F};
    logic [7:0] vr[7] = '{8'h00, 8'h30, 8'h81, 8'h00, 8'hF0, 8'h92, 8'hF0};
    for (int i = 0; i < 7; i++) begin
      run(ops[i], va[i], vb[i], 1);
      chk(resData, vr[i]);
      chk(statusFlags, {5'h04, vr[i][7], vr[i] == 8'h00, 1'b0});
    end
    run(OP_ZERO_SIGN_TEST, 8'h80, 8'h00, 1);
    chk(sawRes, 1'b0);
    chk(resData, 8'hF0);
    chk(statusFlags, 8'h24);
    $display("test_logic done");
  endtask

  task automatic test_invert();
    run(OP_BITWISE_INVERT, 8'h55, 8'h00, 1);
    chk(resData, 8'hAA);
    chk(statusFlags, 8'h25);
    run(OP_TWOS_INVERT, 8'h10, 8'h00, 1);
    chk(resData, 8'hF0);
    chk(statusFlags, 8'h05);
    run(OP_TWOS_INVERT, 8'h80, 8'h00, 1);
    chk(statusFlags, 8'h0D);
    $display("test_invert done");
  endtask

  task automatic test_compare();
    run(OP_COMPARE_WITH_CONSTANT, 8'h10, 8'h10, 1);
    chk(sawRes, 1'b0);
    chk(resData, 8'h80);
    chk(statusFlags, 8'h02);
    run(OP_COMPARE_REGISTERS, 8'h10, 8'h20, 1);
    chk(statusFlags, 8'h05);
    run(OP_COMPARE_WITH_BORROW, 8'h20, 8'h1F, 1);
    chk(statusFlags, 8'h20);
    $display("test_compare done");
  endtask

  task automatic test_word();
    @(posedge core_clk);
    wordIn <= 16'hFFFF;
    run(OP_WORD_ADD_IMMEDIATE, 8'h00, 8'h01, 2);
    chk(sawWord, 1'b1);
    chk(wordData, 16'h0000);
    chk(statusFlags, 8'h23);
    @(posedge core_clk);
    wordIn <= 16'h0000;
    run(OP_WORD_MINUS_IMMEDIATE, 8'h00, 8'h01, 2);
    chk(wordData, 16'hFFFF);
    chk(statusFlags, 8'h35);
    @(posedge core_clk);
    wordIn <= 16'h7FFF;
    run(OP_WORD_ADD_IMMEDIATE, 8'h00, 8'h01, 2);
    chk(wordData, 16'h8000);
    chk(statusFlags, 8'h2C);
    $display("test_word done");
  endtask

  task automatic test_flow();
    @(posedge core_clk);
    zPtr <= 16'h0100;
    brOffset <= 12'hFFB;
    run(OP_JUMP_VIA_POINTER, 8'h00, 8'h00, 2);
    chk(pcOut, 16'h0100);
    run(OP_RELATIVE_JUMP, 8'h00, 8'h00, 2);
    chk(pcOut, 16'h00FC);
    @(posedge core_clk);
    zPtr <= 16'h0200;
    brOffset <= 12'h010;
    run(OP_CALL_VIA_POINTER, 8'h00, 8'h00, 3);
    chk(sawPush, 1'b1);
    chk(pushAddr, 16'h00FD);
    chk(pcOut, 16'h0200);
    run(OP_RELATIVE_CALL, 8'h00, 8'h00, 3);
    chk(pushAddr, 16'h0201);
    chk(pcOut, 16'h0211);
    @(posedge core_clk);
    stackData <= 16'h0300;
    run(OP_ROUTINE_EXIT, 8'h00, 8'h00, 4);
    chk(pcOut, 16'h0300);
    chk(statusFlags, 8'h2C);
    @(posedge core_clk);
    stackData <= 16'h0400;
    run(OP_INTERRUPT_EXIT, 8'h00, 8'h00, 4);
    chk(pcOut, 16'h0400);
    chk(statusFlags, 8'hAC);
    $display("test_flow done");
  endtask

  task automatic test_skip();
    cabx_op_e so[6] = '{OP_COMPARE_SKIP_EQUAL, OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR,
      OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_SET, OP_SKIP_IO_BIT_CLEAR};
    logic [7:0] va[6] = '{8'h5A, 8'h5A, 8'hF7, 8'hF7, 8'h00, 8'h00};
    logic [7:0] vb[6] = '{8'h5A, 8'h5B, 8'h00, 8'h00, 8'h00, 8'h00};
    int dl[6] = '{3, 1, 2, 1, 2, 1};
    logic [15:0] pc;
    pc = 16'h0400;
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      ioData <= 8'h08;
      bitSel <= 3'h3;
      nextTwoWord <= (i < 2);
      run(so[i], va[i], vb[i], dl[i]);
      pc = pc + 16'(dl[i]);
      chk(pcOut, pc);
      chk(statusFlags, 8'hAC);
    end
    @(posedge core_clk);
    ioData <= 8'hF7;
    run(OP_SKIP_IO_BIT_CLEAR, 8'h00, 8'h00, 2);
    pc = pc + 16'h0002;
    chk(pcOut, pc);
    $display("test_skip done");
  endtask

  task automatic test_branch();
    cabx_op_e bo[9] = '{OP_BRANCH_CARRY_SET, OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER,
      OP_BRANCH_EQUAL, OP_BRANCH_NOT_EQUAL, OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR,
      OP_BRANCH_FLAG_CLEAR, OP_BRANCH_FLAG_SET};
    logic [2:0] fs[9] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h2, 3'h0, 3'h7};
    logic tk[9] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    logic [15:0] pc;
    pc = 16'h040C;
    for (int i = 0; i < 9; i++) begin
      @(posedge core_clk);
      brOffset <= 12'h003;
      flagSel <= fs[i];
      run(bo[i], 8'h00, 8'h00, tk[i] ? 2 : 1);
      pc = pc + (tk[i] ? 16'h0004 : 16'h0001);
      chk(pcOut, pc);
    end
    run(OP_COMPARE_REGISTERS, 8'h10, 8'h20, 1);
    run(OP_BRANCH_SAME_OR_HIGHER, 8'h00, 8'h00, 1);
    chk(pcOut, pc + 16'h0002);
    run(OP_COMPARE_REGISTERS, 8'h10, 8'h10, 1);
    run(OP_BRANCH_NOT_EQUAL, 8'h00, 8'h00, 1);
    chk(pcOut, pc + 16'h0004);
    chk(statusFlags, 8'h82);
    $display("test_branch done");
  endtask

  initial begin
    arst_n = 1'b0;
    opValid = 1'b0;
    opCode = OP_NONE;
    opA = 8'h00;
    opB = 8'h00;
    wordIn = 16'h0000;
    zPtr = 16'h0000;
    stackData = 16'h0000;
    bitSel = 3'h0;
    flagSel = 3'h0;
    brOffset = 12'h000;
    nextTwoWord = 1'b0;
    ioData = 8'h00;
    repeat (16) @(posedge core_clk);
    #1;
    chk(opReady, 1'b1);
    chk(pcOut, 16'h0000);
    chk(statusFlags, 8'h00);
    @(posedge core_clk);
    arst_n <= 1'b1;
    test_add();
    test_sub();
    test_logic();
    test_invert();
    test_compare();
    test_word();
    test_flow();
    test_skip();
    test_branch();
    tally_and_finish();
  end
endmodule
